/* File: logic/spbmc_pkg.sv */
// Constants and types of the serial port mode and baud control block.
// Assumes one 200 MHz system clock; register indices are word numbers.
`default_nettype none

package spbmc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] ASYNC_IDX  = 16'hFF70;
  localparam logic [15:0] SYNC_IDX   = 16'hFF72;
  localparam logic [15:0] BAUD_IDX   = 16'hFF73;
  localparam logic [15:0] TXDATA_IDX = 16'hFF74;
  localparam logic [15:0] RXDATA_IDX = 16'hFF75;
  localparam logic [15:0] STATUS_IDX = 16'hFF76;

  // Values after reset and writable-bit masks
  localparam logic [7:0] ASYNC_RST   = 8'h00;
  localparam logic [7:0] SYNC_RST    = 8'h00;
  localparam logic [7:0] BAUD_RST    = 8'h00;
  localparam logic [7:0] ASYNC_WMASK = 8'hFC;
  localparam logic [7:0] SYNC_WMASK  = 8'h86;
  localparam logic [7:0] BAUD_WMASK  = 8'hF0;

  // Field positions
  localparam int TXE_BIT  = 7;
  localparam int RXE_BIT  = 6;
  localparam int PAR_HI   = 5;
  localparam int PAR_LO   = 4;
  localparam int CL_BIT   = 3;
  localparam int SL_BIT   = 2;
  localparam int CSIE_BIT = 7;
  localparam int DIR_BIT  = 2;
  localparam int CSCK_BIT = 1;
  localparam int BSRC_HI  = 7;
  localparam int BSRC_LO  = 4;
  localparam int ST_TXBSY = 0;
  localparam int ST_RXFUL = 1;
  localparam int ST_PERR  = 2;
  localparam int ST_FERR  = 3;
  localparam int ST_OVR   = 4;

  // Baud source codes and counts
  localparam logic [3:0] BAUD_INT_MAX = 4'h7;
  localparam logic [3:0] BAUD_EXT_SEL = 4'h8;
  localparam logic [3:0] OVS_MID      = 4'h7;
  localparam logic [3:0] OVS_LAST     = 4'hF;
  localparam logic [3:0] TX_BASE_BITS = 4'h8;
  localparam logic [3:0] RX_BASE_IDX  = 4'h7;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_ODD  = 2'b10,
    PAR_EVEN = 2'b11
  } spbmc_par_t;

  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_UART = 2'b01,
    MODE_3W   = 2'b10
  } spbmc_mode_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10
  } spbmc_rx_st_t;

endpackage

`default_nettype wire

/* File: logic/spbmc_baud.sv */
// Baud generator: one tick per sixteenth of a bit period.
// Assumes the external clock pin is asynchronous to clk_sys_i.
`default_nettype none

module spbmc_baud
  import spbmc_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] baud_source_i,
  input  wire logic       ext_baud_clock_pin_i,
  output logic            tick16_o
);

  typedef struct packed {
    logic       e1;
    logic       e2;
    logic       e3;
    logic [7:0] div;
    logic       tick;
  } spbmc_brg_t;

  spbmc_brg_t s_ff;
  spbmc_brg_t nxt_s;
  logic [7:0] mask;

  // Tick every 2^n cycles, n = field + 1; bit = 16 ticks
  assign mask = 8'((9'h002 << baud_source_i[2:0]) - 9'h001);

  // Prescaler, pin synchroniser and tick select
  always_comb
  begin
    nxt_s      = s_ff;
    nxt_s.e1   = ext_baud_clock_pin_i;
    nxt_s.e2   = s_ff.e1;
    nxt_s.e3   = s_ff.e2;
    nxt_s.div  = s_ff.div + 8'h01;
    nxt_s.tick = 1'b0;
    if (baud_source_i <= BAUD_INT_MAX)
      nxt_s.tick = (s_ff.div & mask) == mask;
    else if (baud_source_i == BAUD_EXT_SEL)
      nxt_s.tick = s_ff.e2 & ~s_ff.e3;
    if (!rst_n_i)
      nxt_s = '0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    s_ff <= nxt_s;
  end

  assign tick16_o = s_ff.tick;

  // Helper: cycles since last tick, valid only with a steady source
  logic [8:0] gap_q;
  logic [3:0] src_q;
  logic       seen_q;
  always_ff @(posedge clk_sys_i)
  begin
    src_q <= baud_source_i;
    if (!rst_n_i || src_q != baud_source_i)
    begin
      gap_q  <= 9'h001;
      seen_q <= 1'b0;
    end
    else if (tick16_o)
    begin
      gap_q  <= 9'h001;
      seen_q <= 1'b1;
    end
    else
      gap_q <= gap_q + 9'h001;
  end

  chk_int_tick_period: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tick16_o && seen_q && src_q == baud_source_i && baud_source_i <= BAUD_INT_MAX
    |-> gap_q == (9'h002 << baud_source_i[2:0]))
    else $error("internal baud tick period wrong");

  chk_ext_tick_edge: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tick16_o && $past(baud_source_i) == BAUD_EXT_SEL
    |-> $past(s_ff.e2) && !$past(s_ff.e3))
    else $error("external tick without pin edge");

endmodule // spbmc_baud

`default_nettype wire

/* File: logic/spbmc_top.sv */
// Serial port mode control, baud generation and UART frame engine.
// Assumes an Avalon-MM master on clk_sys_i and asynchronous line pins.
//
// Functional notes
// - Internal baud equals system clock over 2^(n+1) times 8.
// - Upper nibble of baud control picks n; 10H is n=2, 70H n=8.
// - Baud control 80H divides the external baud clock pin by 16.
// - 31.25 kbps is reachable, e.g. from a 500.0 kHz external clock.
// - Three modes exist: stop, asynchronous UART, 3-wire serial I/O.
// - Stop mode transfers nothing and releases clock and data pins.
// - Sync mode register at FF72H resets 00H; bits 7, 2, 1 defined.
// - 3-wire enable bit stops the mode at 0, enables it at 1.
// - 3-wire clock select 0 takes pin clock, 1 the baud generator.
// - Async mode register at FF70H resets 00H; fields in bits 7..2.
// - UART sends and receives a character after a start bit, full duplex.
// - Parity 00 none, 01 zero bit without check, 10 odd, 11 even.
// - Length bit 0 gives 7, 1 gives 8 bits; stop bit 0 one, 1 two.
// - Source field 1000 selects external pin clock; codes 1001 to 1111 unused.
// - Receiver checks only one stop bit even when two are sent.
// - 7-bit characters drop bit 7 on send, read bit 7 as zero.
//
// Decided for this implementation: the Avalon-MM register port.
`default_nettype none

module spbmc_top
  import spbmc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [17:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        rxd_pin_i,
  output logic             txd_pin_o,
  output logic             txd_pin_oe_o,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_o,
  input  wire logic        ext_baud_clock_pin_i,
  output logic             gpio_release_o
);

  typedef struct packed {
    logic         ack;
    logic [31:0]  rdata;
    logic [7:0]   asyn;
    logic [7:0]   sync;
    logic [7:0]   baud;
    logic         rx_s1;
    logic         rx_s2;
    logic         sck_s1;
    logic         sck_s2;
    logic         tx_busy;
    logic [11:0]  tx_sh;
    logic [3:0]   tx_bits;
    logic [3:0]   tx_ph;
    spbmc_rx_st_t rx_st;
    logic [3:0]   rx_ph;
    logic [3:0]   rx_cnt;
    logic [9:0]   rx_sh;
    logic [7:0]   rx_data;
    logic         rx_full;
    logic         perr;
    logic         ferr;
    logic         ovr;
    logic [3:0]   sck_ph;
  } spbmc_state_t;

  spbmc_state_t s_ff;
  spbmc_state_t nxt_s;

  logic        tick16;
  logic [15:0] idx;
  logic        req;
  logic        bus_do;
  logic        wr_lo;
  logic [7:0]  wd;
  logic [31:0] rd_mux;
  logic        txe;
  logic        rxe;
  logic        cl;
  logic        sl;
  spbmc_par_t  par;
  logic        par_on;
  logic        three_w;
  logic        csck;
  logic        uart_on;
  spbmc_mode_t mode;
  logic        sck_lvl;
  logic [7:0]  tx_d8;
  logic        tx_p;
  logic [8:0]  tx_pay;
  logic [11:0] tx_frame;
  logic [3:0]  tx_len;
  logic        tx_go;
  logic [3:0]  rx_last;
  logic [9:0]  rx_full_sh;
  logic [9:0]  rx_val;
  logic [7:0]  rx_d8;
  logic        rx_pbit;
  logic        rx_done;
  logic        rx_perr;
  logic        rd_rx;
  logic        wr_st;

  spbmc_baud u_baud (
    .clk_sys_i            (clk_sys_i),
    .rst_n_i              (rst_n_i),
    .baud_source_i        (s_ff.baud[BSRC_HI:BSRC_LO]),
    .ext_baud_clock_pin_i (ext_baud_clock_pin_i),
    .tick16_o             (tick16)
  );

  // Bus decode; one wait state, so read data come from a flop
  assign idx    = avs_address_i[17:2];
  assign req    = avs_read_i | avs_write_i;
  assign bus_do = req & s_ff.ack;
  assign wr_lo  = bus_do & avs_write_i & avs_byteenable_i[0];
  assign wd     = avs_writedata_i[7:0];
  assign rd_rx  = bus_do & avs_read_i & (idx == RXDATA_IDX);
  assign wr_st  = wr_lo & (idx == STATUS_IDX);
  assign avs_waitrequest_o = req & ~s_ff.ack;
  assign avs_readdata_o    = s_ff.rdata;

  // Read mux; unmapped words read as zero
  assign rd_mux =
    (idx == ASYNC_IDX)  ? {24'h000000, s_ff.asyn} :
    (idx == SYNC_IDX)   ? {24'h000000, s_ff.sync} :
    (idx == BAUD_IDX)   ? {24'h000000, s_ff.baud} :
    (idx == RXDATA_IDX) ? {24'h000000, s_ff.rx_data} :
    (idx == STATUS_IDX) ? {26'h0, sck_lvl, s_ff.ovr, s_ff.ferr,
                           s_ff.perr, s_ff.rx_full, s_ff.tx_busy} :
    32'h00000000;

  // Configuration fields
  assign txe     = s_ff.asyn[TXE_BIT];
  assign rxe     = s_ff.asyn[RXE_BIT];
  assign cl      = s_ff.asyn[CL_BIT];
  assign sl      = s_ff.asyn[SL_BIT];
  assign par     = spbmc_par_t'(s_ff.asyn[PAR_HI:PAR_LO]);
  assign par_on  = par != PAR_NONE;
  assign three_w = s_ff.sync[CSIE_BIT];
  assign csck    = s_ff.sync[CSCK_BIT];

  // Mode: 3-wire enable wins, then any UART direction, else stop
  assign uart_on = ~three_w & (txe | rxe);
  assign mode    = three_w ? MODE_3W : (uart_on ? MODE_UART : MODE_STOP);

  // Stop mode hands the pins back to the port logic
  assign gpio_release_o        = mode == MODE_STOP;
  assign txd_pin_o             = s_ff.tx_sh[0];
  assign txd_pin_oe_o          = (mode == MODE_UART) & txe;
  assign serial_clock_pin_o    = s_ff.sck_ph[3];
  assign serial_clock_pin_oe_o = three_w & csck;
  assign sck_lvl               = csck ? s_ff.sck_ph[3] : s_ff.sck_s2;

  // Transmit frame; 7-bit mode ignores data bit 7
  assign tx_d8 = cl ? wd : {1'b0, wd[6:0]};
  always_comb
  begin
    unique case (par)
      PAR_ODD:  tx_p = ~^tx_d8;
      PAR_EVEN: tx_p = ^tx_d8;
      PAR_ZERO: tx_p = 1'b0;
      PAR_NONE: tx_p = 1'b1;
    endcase
  end
  // With no parity the slot holds a stop level, so ones follow
  assign tx_pay   = cl ? {tx_p, tx_d8} : {1'b1, tx_p, tx_d8[6:0]};
  assign tx_frame = {2'b11, tx_pay, 1'b0};
  assign tx_len   = TX_BASE_BITS + {3'h0, cl} + {3'h0, par_on} + {3'h0, sl};
  assign tx_go    = wr_lo & (idx == TXDATA_IDX) & txe & ~three_w & ~s_ff.tx_busy;

  // Receive word; only one stop bit is sampled
  assign rx_last    = RX_BASE_IDX + {3'h0, cl} + {3'h0, par_on};
  assign rx_full_sh = {s_ff.rx_s2, s_ff.rx_sh[9:1]};
  assign rx_val     = rx_full_sh >> (2'h2 - {1'b0, cl} - {1'b0, par_on});
  assign rx_d8      = cl ? rx_val[7:0] : {1'b0, rx_val[6:0]};
  assign rx_pbit    = cl ? rx_val[8] : rx_val[7];
  assign rx_done    = (s_ff.rx_st == RX_DATA) & tick16 & (s_ff.rx_ph == OVS_LAST)
                      & (s_ff.rx_cnt == rx_last);
  always_comb
  begin
    unique case (par)
      PAR_ODD:  rx_perr = ~(^{rx_d8, rx_pbit});
      PAR_EVEN: rx_perr = ^{rx_d8, rx_pbit};
      PAR_ZERO: rx_perr = 1'b0;
      PAR_NONE: rx_perr = 1'b0;
    endcase
  end

  // Next state of the whole block
  always_comb
  begin
    nxt_s        = s_ff;
    nxt_s.ack    = req & ~s_ff.ack;
    nxt_s.rx_s1  = rxd_pin_i;
    nxt_s.rx_s2  = s_ff.rx_s1;
    nxt_s.sck_s1 = serial_clock_pin_i;
    nxt_s.sck_s2 = s_ff.sck_s1;
    if (req & ~s_ff.ack)
      nxt_s.rdata = rd_mux;

    // Register writes; must-be-zero bits stay zero
    if (wr_lo & (idx == ASYNC_IDX))
      nxt_s.asyn = wd & ASYNC_WMASK;
    if (wr_lo & (idx == SYNC_IDX))
      nxt_s.sync = wd & SYNC_WMASK;
    if (wr_lo & (idx == BAUD_IDX))
      nxt_s.baud = wd & BAUD_WMASK;

    // 3-wire serial clock divider, one period per bit
    if (tick16)
      nxt_s.sck_ph = s_ff.sck_ph + 4'h1;

    // Transmitter: shift out LSB first, ones fill behind
    if (s_ff.tx_busy && tick16)
    begin
      nxt_s.tx_ph = s_ff.tx_ph + 4'h1;
      if (s_ff.tx_ph == OVS_LAST)
      begin
        nxt_s.tx_sh   = {1'b1, s_ff.tx_sh[11:1]};
        nxt_s.tx_bits = s_ff.tx_bits - 4'h1;
        if (s_ff.tx_bits == 4'h0)
          nxt_s.tx_busy = 1'b0;
      end
    end
    if (tx_go)
    begin
      nxt_s.tx_busy = 1'b1;
      nxt_s.tx_sh   = tx_frame;
      nxt_s.tx_bits = tx_len;
      nxt_s.tx_ph   = 4'h0;
    end
    // Dropping the enable aborts the frame and idles the line
    if (!txe || three_w)
    begin
      nxt_s.tx_busy = 1'b0;
      nxt_s.tx_sh   = 12'hFFF;
    end

    // Receiver, 16x oversampled
    unique case (s_ff.rx_st)
      RX_IDLE:
      begin
        if (tick16 && !s_ff.rx_s2)
        begin
          nxt_s.rx_st = RX_START;
          nxt_s.rx_ph = 4'h0;
        end
      end
      RX_START:
      begin
        if (tick16)
        begin
          nxt_s.rx_ph = s_ff.rx_ph + 4'h1;
          // Glitch filter: start must still be low mid-bit
          if (s_ff.rx_ph == OVS_MID)
          begin
            nxt_s.rx_st  = s_ff.rx_s2 ? RX_IDLE : RX_DATA;
            nxt_s.rx_ph  = 4'h0;
            nxt_s.rx_cnt = 4'h0;
          end
        end
      end
      RX_DATA:
      begin
        if (tick16)
        begin
          nxt_s.rx_ph = s_ff.rx_ph + 4'h1;
          if (s_ff.rx_ph == OVS_LAST)
          begin
            nxt_s.rx_sh  = rx_full_sh;
            nxt_s.rx_cnt = s_ff.rx_cnt + 4'h1;
            if (s_ff.rx_cnt == rx_last)
              nxt_s.rx_st = RX_IDLE;
          end
        end
      end
      default:
        nxt_s.rx_st = RX_IDLE;
    endcase
    if (!rxe || three_w)
      nxt_s.rx_st = RX_IDLE;

    // Received word and flags; a new event beats a clear
    if (rx_done)
      nxt_s.rx_data = rx_d8;
    nxt_s.rx_full = (s_ff.rx_full & ~rd_rx) | rx_done;
    nxt_s.perr = (s_ff.perr & ~(wr_st & wd[ST_PERR])) | (rx_done & rx_perr);
    nxt_s.ferr = (s_ff.ferr & ~(wr_st & wd[ST_FERR])) | (rx_done & ~s_ff.rx_s2);
    nxt_s.ovr  = (s_ff.ovr & ~(wr_st & wd[ST_OVR]))
                 | (rx_done & s_ff.rx_full & ~rd_rx);

    if (!rst_n_i)
    begin
      nxt_s        = '0;
      nxt_s.asyn   = ASYNC_RST;
      nxt_s.sync   = SYNC_RST;
      nxt_s.baud   = BAUD_RST;
      nxt_s.rx_s1  = 1'b1;
      nxt_s.rx_s2  = 1'b1;
      nxt_s.tx_sh  = 12'hFFF;
      nxt_s.rx_st  = RX_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    s_ff <= nxt_s;
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence tx_launch;
    !s_ff.tx_busy ##1 s_ff.tx_busy;
  endsequence

  sequence rx_last_sample;
    s_ff.rx_st == RX_DATA && tick16 && s_ff.rx_ph == OVS_LAST && s_ff.rx_cnt == rx_last;
  endsequence

  chk_stop_pins_free: assert property (
    mode == MODE_STOP |-> !txd_pin_oe_o && !serial_clock_pin_oe_o && gpio_release_o)
    else $error("stop mode still drives pins");

  chk_mode_reg_reset: assert property (
    $rose(rst_n_i) |-> s_ff.asyn == ASYNC_RST && s_ff.sync == SYNC_RST && s_ff.baud == BAUD_RST)
    else $error("mode registers not cleared by reset");

  chk_tx_start_low: assert property (
    tx_launch |-> !txd_pin_o ##1 !txd_pin_o)
    else $error("frame does not open with a low start bit");

  chk_tx_frame_len: assert property (
    tx_launch |-> s_ff.tx_bits == TX_BASE_BITS + {3'h0, cl} + {3'h0, par_on} + {3'h0, sl})
    else $error("frame length does not match settings");

  chk_zero_parity: assert property (
    $rose(s_ff.tx_busy) && par == PAR_ZERO |-> (cl ? s_ff.tx_sh[9] : s_ff.tx_sh[8]) == 1'b0)
    else $error("zero parity slot not low");

  chk_rx_bit7_zero: assert property (
    $rose(s_ff.rx_full) && !cl |-> s_ff.rx_data[7] == 1'b0)
    else $error("7-bit character returned bit 7 set");

  chk_rx_one_stop: assert property (
    rx_last_sample |=> s_ff.rx_st == RX_IDLE || !rxe)
    else $error("receiver waited for a second stop bit");

  chk_rx_centre: assert property (
    s_ff.rx_st == RX_START && tick16 && s_ff.rx_ph == OVS_MID && !s_ff.rx_s2 && rxe && !three_w
    |=> s_ff.rx_st == RX_DATA && s_ff.rx_cnt == 4'h0)
    else $error("start bit not confirmed at centre");

  chk_sck_from_brg: assert property (
    three_w && csck |-> serial_clock_pin_oe_o && serial_clock_pin_o == s_ff.sck_ph[3])
    else $error("3-wire clock not driven from generator");

endmodule // spbmc_top

`default_nettype wire

/* File: bench/spbmc_remote.sv */
// Remote serial device model: captures frames from the block, sends frames to it.
// Assumes a bit period given in system clocks and an idle-high line on both wires.
`default_nettype none

module spbmc_remote
(
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] bit_clks_i,
  input  wire logic        txd_i,
  output logic             rxd_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [11:0] cap;
  int          cap_cnt = 0;

  initial rxd_o = 1'b1;

  // Start edge, then mid-bit samples; twelve covers the longest frame
  always
  begin
    @(negedge txd_i);
    repeat (bit_clks_i / 2) @(posedge clk_sys_i);
    for (int i = 0; i < 12; i++)
    begin
      cap[i] = txd_i;
      repeat (bit_clks_i) @(posedge clk_sys_i);
    end
    cap_cnt++;
  end

  // Sends bits LSB first; line returns to idle high after the last one
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys_i);
      rxd_o <= bits[i];
      repeat (bit_clks_i - 1) @(posedge clk_sys_i);
    end
    @(posedge clk_sys_i);
    rxd_o <= 1'b1;
  endtask
endmodule // spbmc_remote

`default_nettype wire

/* File: bench/test_serial_port_baud_and_mode_control.sv */
// Bench of the serial port block: register bus, baud rates, frames both ways.
// Assumes the remote model beside the pins and an Avalon-MM slave with waits.
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end

module test_serial_port_baud_and_mode_control
  import spbmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0]  TXC [4] = '{8'h88, 8'h94, 8'hAC, 8'hB0};
  localparam logic [7:0]  RXC [5] = '{8'h78, 8'h78, 8'h78, 8'h50, 8'h7C};
  localparam logic [7:0]  RXD [5] = '{8'hA5, 8'hA5, 8'hA5, 8'hC3, 8'h3C};
  localparam logic [15:0] RXX [5] = '{16'h0, 16'h0200, 16'h0400, 16'h0100, 16'h0};
  localparam logic [7:0]  RXE [5] = '{8'hA5, 8'hA5, 8'hA5, 8'h43, 8'hC3};
  localparam logic [7:0]  RXS [5] = '{8'h02, 8'h06, 8'h0A, 8'h02, 8'h12};

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [17:0] adr = '0;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic        wreq;
  logic        rxd;
  logic        txd;
  logic        txd_oe;
  logic        txd_line;
  logic        sck_i = 1'b0;
  logic        sck_o;
  logic        sck_oe;
  logic [3:0]  ext_cnt = '0;
  logic        gpio_rel;
  logic [15:0] bit_clks = 16'd64;
  int          cyc = 0;
  int          errors = 0;
  int          n_compared = 0;

  always #2.5 clk = ~clk;

  // Free-running counters; external baud pin rises every 8 clocks
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ext_cnt <= ext_cnt + 4'h1;
  end

  // Released transmit line is pulled up, as an idle line should be
  assign txd_line = txd_oe ? txd : 1'b1;

  spbmc_top u_spbmc_top (
    .clk_sys_i             (clk),
    .rst_n_i               (rst_n),
    .avs_address_i         (adr),
    .avs_read_i            (rd_en),
    .avs_write_i           (wr_en),
    .avs_writedata_i       (wdat),
    .avs_byteenable_i      (4'hF),
    .avs_readdata_o        (rdat),
    .avs_waitrequest_o     (wreq),
    .rxd_pin_i             (rxd),
    .txd_pin_o             (txd),
    .txd_pin_oe_o          (txd_oe),
    .serial_clock_pin_i    (sck_i),
    .serial_clock_pin_o    (sck_o),
    .serial_clock_pin_oe_o (sck_oe),
    .ext_baud_clock_pin_i  (ext_cnt[2]),
    .gpio_release_o        (gpio_rel)
  );

  spbmc_remote u_spbmc_remote (
    .clk_sys_i  (clk),
    .bit_clks_i (bit_clks),
    .txd_i      (txd_line),
    .rxd_o      (rxd)
  );

  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic give_up();
    errors++;
    $display("wrong value wait expected done seen timeout");
    print_verdict();
  endtask

  // One access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int k;
    k = 0;
    @(posedge clk);
    adr   <= {idx, 2'b00};
    wr_en <= wr;
    rd_en <= ~wr;
    wdat  <= {24'h0, wd};
    do
    begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 100);
    // Write lands and read data are taken at this same edge
    rd = rdat[7:0];
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (k >= 100)
      give_up();
    // Let the edge's updates settle before anyone looks at outputs
    @(negedge clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] dummy;
    bus(1'b1, idx, d, dummy);
  endtask

  task automatic rdv(input logic [15:0] idx, output logic [7:0] d);
    bus(1'b0, idx, 8'h00, d);
  endtask

  // Cycles until the 3-wire clock output next rises
  task automatic rise(output int c);
    logic p;
    c = 0;
    p = sck_o;
    while (!(p === 1'b0 && sck_o === 1'b1) && c < 20000)
    begin
      p = sck_o;
      @(negedge clk);
      c++;
    end
    if (c >= 20000)
      give_up();
  endtask

  // Expected line bits of one character, start bit at index 0
  function automatic logic [15:0] frame(input logic [7:0] cfg, input logic [7:0] d, output int n);
    logic [15:0] b;
    int          len;
    logic        p;
    b = 16'hFFFF;
    b[0] = 1'b0;
    len = cfg[3] ? 8 : 7;
    p = 1'b0;
    for (int i = 0; i < len; i++)
    begin
      b[1 + i] = d[i];
      p ^= d[i];
    end
    n = 1 + len;
    if (cfg[5:4] != 2'b00)
    begin
      b[n] = (cfg[5:4] == 2'b01) ? 1'b0 : (cfg[4] ? p : ~p);
      n++;
    end
    n += cfg[2] ? 2 : 1;
    return b;
  endfunction

  // Sends one character; busy time bounds the bit count, stops included
  task automatic tx_case(input logic [7:0] cfg, input logic [7:0] d, input int bc);
    logic [15:0] f;
    logic [7:0]  st;
    int          n;
    int          t;
    int          c;
    f = frame(cfg, d, n);
    c = u_spbmc_remote.cap_cnt;
    wr(ASYNC_IDX, cfg);
    wr(TXDATA_IDX, d);
    t = cyc;
    // A second character while busy must be refused, not reload the frame
    wr(TXDATA_IDX, ~d);
    do
      rdv(STATUS_IDX, st);
    while (st[ST_TXBSY] !== 1'b0 && cyc - t < 20000);
    if (st[ST_TXBSY] !== 1'b0)
      give_up();
    t = cyc - t;
    `CHK("tx length", 1'b1, (t >= n * bc - bc / 8) && (t <= n * bc + bc / 8 + 8))
    for (int k = 0; k < 20000 && u_spbmc_remote.cap_cnt == c; k++)
      @(negedge clk);
    if (u_spbmc_remote.cap_cnt == c)
      give_up();
    `CHK("tx frame", f[11:0], u_spbmc_remote.cap)
  endtask

  initial
  begin
    logic [7:0]  rd;
    logic [15:0] f;
    int          n;
    int          c;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK("gpio release", 1'b1, gpio_rel)
    `CHK("txd oe", 1'b0, txd_oe)
    rdv(ASYNC_IDX, rd);
    `CHK("async reset", 8'h00, rd)
    rdv(SYNC_IDX, rd);
    `CHK("sync reset", 8'h00, rd)
    // Unmapped place reads zero and keeps nothing
    wr(16'hFF71, 8'hFF);
    rdv(16'hFF71, rd);
    `CHK("unmapped", 8'h00, rd)
    wr(ASYNC_IDX, 8'hFF);
    rdv(ASYNC_IDX, rd);
    `CHK("async bits", 8'hFC, rd)
    wr(ASYNC_IDX, 8'h00);
    wr(SYNC_IDX, 8'hFF);
    rdv(SYNC_IDX, rd);
    `CHK("sync bits", 8'h86, rd)
    // 3-wire on the baud generator clock: period is one bit time
    wr(SYNC_IDX, 8'h82);
    `CHK("sck oe", 1'b1, sck_oe)
    `CHK("gpio busy", 1'b0, gpio_rel)
    for (int k = 1; k <= 7; k++)
    begin
      wr(BAUD_IDX, 8'(k << 4));
      // First rise may still carry a tick of the old rate
      rise(c);
      rise(c);
      rise(c);
      `CHK("sck period", 32 << k, c)
    end
    // Pin clock source: level visible in status bit 5
    wr(SYNC_IDX, 8'h80);
    `CHK("sck oe pin", 1'b0, sck_oe)
    for (int v = 0; v < 2; v++)
    begin
      @(posedge clk);
      sck_i <= v[0];
      repeat (4) @(posedge clk);
      rdv(STATUS_IDX, rd);
      `CHK("pin clock", v[0], rd[5])
    end
    wr(SYNC_IDX, 8'h00);
    wr(BAUD_IDX, 8'h10);
    for (int k = 0; k < 4; k++)
      tx_case(TXC[k], 8'hD3, 64);
    `CHK("txd oe uart", 1'b1, txd_oe)
    // External baud pin divided by 16
    wr(BAUD_IDX, 8'h80);
    bit_clks = 16'd128;
    tx_case(8'h88, 8'h5A, 128);
    wr(BAUD_IDX, 8'h10);
    bit_clks = 16'd64;
    // Receive: good, bad parity, bad stop, zero parity, overrun on two stops
    for (int k = 0; k < 5; k++)
    begin
      wr(ASYNC_IDX, RXC[k]);
      f = frame(RXC[k] & 8'hFB, RXD[k], n) ^ RXX[k];
      u_spbmc_remote.send(f, n);
      if (k == 4)
      begin
        f = frame(8'h78, ~RXD[k], n);
        u_spbmc_remote.send(f, n);
      end
      rdv(STATUS_IDX, rd);
      `CHK("rx status", RXS[k], rd & 8'h1E)
      rdv(RXDATA_IDX, rd);
      `CHK("rx data", RXE[k], rd)
      wr(STATUS_IDX, 8'h1C);
    end
    // Transmit refused while the transmitter is disabled
    wr(ASYNC_IDX, 8'h40);
    wr(TXDATA_IDX, 8'h55);
    rdv(STATUS_IDX, rd);
    `CHK("tx refused", 1'b0, rd[ST_TXBSY])
    wr(ASYNC_IDX, 8'h00);
    `CHK("gpio stop", 1'b1, gpio_rel)
    print_verdict();
  end
endmodule // test_serial_port_baud_and_mode_control

`default_nettype wire
